// >>> shared/qctp_pkg.sv
// Package of constants and types for the queue command and transmit pointer block.
package qctp_pkg;
	localparam logic [7:0]  ADDR_RX_QUEUE_COMMAND_OFS   = 8'h82;
	localparam logic [7:0]  ADDR_TX_FRAME_DATA_POINTER_OFS  = 8'h84;
	localparam logic [7:0]  ADDR_DATA_OFS    = 8'h00;
	localparam logic [7:0]  ADDR_TXQCR_OFS   = 8'h80;
	localparam logic [7:0]  ADDR_ISR_OFS     = 8'h92;
	localparam logic [7:0]  ADDR_BTHR_OFS    = 8'h8E;
	localparam logic [7:0]  ADDR_FTHR_OFS    = 8'h9C;
	localparam int          BIT_BYTE_EN      = 6;
	localparam int          BIT_FRAME_EN     = 5;
	localparam int          BIT_AUTO_DEQ     = 4;
	localparam int          BIT_START_ACC    = 3;
	localparam int          BIT_REL_ERR      = 0;
	localparam int          BIT_BYTE_STS     = 11;
	localparam int          BIT_FRAME_STS    = 10;
	localparam int          BIT_AUTO_INC     = 14;
	localparam int          BIT_ISR_RX       = 13;
	localparam int          BIT_MAN_ENQ      = 0;
	localparam int          PTR_W            = 11;
	localparam logic [15:0] RESET_WORD       = 16'h0000;
	localparam int          FIFO_W           = 32;
	localparam int          FIFO_D           = 16;

	typedef struct packed {
		logic [3:0]  be;
		logic [31:0] data;
	} qctp_word_type;

	typedef struct packed {
		logic        frame_end;
		logic        error_frame;
		logic [15:0] byte_count;
		logic [7:0]  frame_count;
	} qctp_rxstat_type;
endpackage

// >>> core/qctp_fifo.sv
// Parameterised FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module qctp_fifo #(
	parameter int W = 32,
	parameter int D = 16
) (
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW:0]  wp_r, wp_nxt, rp_r, rp_nxt;
	logic         push, pop;

	assign in_ready  = (wp_r - rp_r) != (AW+1)'(D);
	assign out_valid = wp_r != rp_r;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		wp_nxt = push ? wp_r + 1'b1 : wp_r;
		rp_nxt = pop ? rp_r + 1'b1 : rp_r;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wp_r <= '0;
			rp_r <= '0;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp_r[AW-1:0]] <= in_data;
		end
	end

	assign out_data = mem[rp_r[AW-1:0]];
	// The head entry comes from the write register array, kept stable until popped.
endmodule // qctp_fifo

// >>> core/qctp_core.sv
// Queue command register, transmit frame pointer and host bus decode.
`timescale 1ns/1ps
module qctp_core #(
	parameter int W = qctp_pkg::FIFO_W,
	parameter int D = qctp_pkg::FIFO_D
) (
	input  wire logic                      REF_CLK,
	input  wire logic                      NRST,
	input  wire logic                      CSN,
	input  wire logic                      RD_N,
	input  wire logic                      WR_N,
	input  wire logic [7:0]                ADDR,
	input  wire logic [3:0]                BE_N,
	input  wire logic [31:0]               DIN,
	output logic [31:0]                    DOUT,
	output logic                           DOUT_OE,
	input  wire qctp_pkg::qctp_rxstat_type RX_STAT,
	input  wire logic [31:0]               RX_DATA,
	output logic                           RX_READ,
	output logic                           RX_DEQUEUE,
	output logic                           RX_RELEASE,
	input  wire logic                      RX_RELEASED,
	output logic                           RX_INT,
	output logic [1:0]                     RX_STATUS,
	output logic                           TX_VALID,
	input  wire logic                      TX_READY,
	output qctp_pkg::qctp_word_type        TX_WORD,
	output logic [10:0]                    TX_PTR,
	output logic                           TX_ENQUEUE,
	input  wire logic [10:0]               TX_NEXT_FREE,
	output logic                           TX_FULL
);
	// Two-stage synchronisers for the asynchronous host strobes.
	logic [2:0] s1_r, s2_r, s3_r;
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			s1_r <= 3'h7;
			s2_r <= 3'h7;
			s3_r <= 3'h7;
		end else begin
			s1_r <= {CSN, RD_N, WR_N};
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	logic cs_act, rd_act, wr_act, rd_pulse, wr_pulse;
	assign cs_act   = !s2_r[2];
	assign rd_act   = cs_act && !s2_r[1];
	assign wr_act   = cs_act && !s2_r[0];
	assign rd_pulse = rd_act && s3_r[1];
	assign wr_pulse = wr_act && s3_r[0];

	////////////////////////////////////////////////////////////////////////////////
	logic [15:0] rx_queue_command_r, rx_queue_command_nxt;
	logic        auto_inc_r, auto_inc_nxt;
	logic [10:0] ptr_r, ptr_nxt;
	logic [15:0] bthr_r, bthr_nxt;
	logic [7:0]  fthr_r, fthr_nxt;
	logic [1:0]  sts_r, sts_nxt;
	logic        int_r, int_nxt;
	logic        enq_r, enq_nxt;
	logic [31:0] dout_r, dout_nxt;
	logic        rel_req_r, rel_req_nxt;
	logic        start_acc;
	logic        reg_sel_q, reg_sel_t, reg_sel_d, reg_sel_i, reg_sel_b, reg_sel_f, reg_sel_c;
	logic [2:0]  step;
	logic        fifo_in_ready;
	qctp_pkg::qctp_word_type fifo_in;
	logic        byte_hit, frame_hit;

	assign start_acc = rx_queue_command_r[qctp_pkg::BIT_START_ACC];
	// During queue access only the command register decodes; others are blocked.
	always_comb begin
		reg_sel_q = ADDR == qctp_pkg::ADDR_RX_QUEUE_COMMAND_OFS;
		reg_sel_t = !start_acc && ADDR == qctp_pkg::ADDR_TX_FRAME_DATA_POINTER_OFS;
		reg_sel_d = !start_acc && ADDR == qctp_pkg::ADDR_DATA_OFS;
		reg_sel_i = !start_acc && ADDR == qctp_pkg::ADDR_ISR_OFS;
		reg_sel_b = !start_acc && ADDR == qctp_pkg::ADDR_BTHR_OFS;
		reg_sel_f = !start_acc && ADDR == qctp_pkg::ADDR_FTHR_OFS;
		reg_sel_c = !start_acc && ADDR == qctp_pkg::ADDR_TXQCR_OFS;
	end

	// Access size from byte enables: one, two or four bytes.
	always_comb begin
		case (~BE_N)
			4'hF:    step = 3'h4;
			4'h3,
			4'hC:    step = 3'h2;
			default: step = 3'h1;
		endcase
	end

	assign byte_hit  = RX_STAT.byte_count > bthr_r;
	assign frame_hit = RX_STAT.frame_count > fthr_r;

	always_comb begin
		rx_queue_command_nxt    = rx_queue_command_r;
		auto_inc_nxt = auto_inc_r;
		ptr_nxt      = ptr_r;
		bthr_nxt     = bthr_r;
		fthr_nxt     = fthr_r;
		sts_nxt      = sts_r;
		int_nxt      = int_r;
		enq_nxt      = 1'b0;
		dout_nxt     = dout_r;
		rel_req_nxt  = 1'b0;
		if ((rx_queue_command_r[qctp_pkg::BIT_BYTE_EN] && byte_hit)
		    || (rx_queue_command_r[qctp_pkg::BIT_FRAME_EN] && frame_hit)) begin
			int_nxt = 1'b1;
		end
		if (RX_RELEASED) begin
			rx_queue_command_nxt[qctp_pkg::BIT_REL_ERR] = 1'b0;
		end
		if (rd_pulse) begin
			if (start_acc) begin
				dout_nxt = RX_DATA;
			end else if (reg_sel_q) begin
				dout_nxt = {16'h0000, 4'h0, sts_r, 3'h0, rx_queue_command_r[6:4], 3'h0,
				            rx_queue_command_r[qctp_pkg::BIT_REL_ERR]};
			end else if (reg_sel_t) begin
				dout_nxt = {17'h00000, auto_inc_r, 3'h0, ptr_r};
			end else if (reg_sel_i) begin
				dout_nxt = {18'h00000, int_r, 13'h0000};
			end else if (reg_sel_b) begin
				dout_nxt = {16'h0000, bthr_r};
			end else if (reg_sel_f) begin
				dout_nxt = {24'h000000, fthr_r};
			end else begin
				dout_nxt = 32'h00000000;
			end
		end
		if (wr_pulse) begin
			if (reg_sel_q) begin
				rx_queue_command_nxt[6:3] = DIN[6:3];
				if (DIN[qctp_pkg::BIT_REL_ERR]) begin
					rx_queue_command_nxt[qctp_pkg::BIT_REL_ERR] = 1'b1;
					rel_req_nxt = 1'b1;
				end
			end else if (start_acc) begin
				if (fifo_in_ready && auto_inc_r) begin
					ptr_nxt = ptr_r + 11'(step);
				end
			end else if (reg_sel_t) begin
				auto_inc_nxt = DIN[qctp_pkg::BIT_AUTO_INC];
			end else if (reg_sel_d) begin
				if (fifo_in_ready && auto_inc_r) begin
					ptr_nxt = ptr_r + 11'(step);
				end
			end else if (reg_sel_i && DIN[qctp_pkg::BIT_ISR_RX]) begin
				sts_nxt = {byte_hit, frame_hit};
				int_nxt = 1'b0;
			end else if (reg_sel_b) begin
				bthr_nxt = DIN[15:0];
			end else if (reg_sel_f) begin
				fthr_nxt = DIN[7:0];
			end else if (reg_sel_c && DIN[qctp_pkg::BIT_MAN_ENQ]) begin
				enq_nxt = 1'b1;
				ptr_nxt = TX_NEXT_FREE;
			end
		end
	end

	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			rx_queue_command_r    <= qctp_pkg::RESET_WORD;
			auto_inc_r <= 1'b0;
			ptr_r      <= '0;
			bthr_r     <= '0;
			fthr_r     <= '0;
			sts_r      <= '0;
			int_r      <= 1'b0;
			enq_r      <= 1'b0;
			dout_r     <= '0;
			rel_req_r  <= 1'b0;
		end else begin
			rx_queue_command_r    <= rx_queue_command_nxt;
			auto_inc_r <= auto_inc_nxt;
			ptr_r      <= ptr_nxt;
			bthr_r     <= bthr_nxt;
			fthr_r     <= fthr_nxt;
			sts_r      <= sts_nxt;
			int_r      <= int_nxt;
			enq_r      <= enq_nxt;
			dout_r     <= dout_nxt;
			rel_req_r  <= rel_req_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Transmit data path through the FIFO; full refuses the write.
	logic fifo_push;
	assign fifo_push  = wr_pulse && !reg_sel_q && (start_acc || reg_sel_d);
	assign fifo_in.be   = start_acc ? 4'hF : ~BE_N;
	assign fifo_in.data = DIN;

	qctp_fifo #(.W(36), .D(D)) i_qctp_fifo (
		.clk       (REF_CLK),
		.nrst      (NRST),
		.in_valid  (fifo_push),
		.in_ready  (fifo_in_ready),
		.in_data   (fifo_in),
		.out_valid (TX_VALID),
		.out_ready (TX_READY),
		.out_data  (TX_WORD)
	);

	assign RX_READ    = rd_pulse && start_acc;
	assign RX_DEQUEUE = rx_queue_command_r[qctp_pkg::BIT_AUTO_DEQ] && RX_STAT.frame_end;
	assign RX_RELEASE = rel_req_r;
	assign RX_INT     = int_r;
	assign RX_STATUS  = sts_r;
	assign TX_PTR     = ptr_r;
	assign TX_ENQUEUE = enq_r;
	assign TX_FULL    = !fifo_in_ready;
	assign DOUT       = dout_r;
	assign DOUT_OE    = rd_act;

	////////////////////////////////////////////////////////////////////////////////
	property p_ptr_hold;
		@(posedge REF_CLK) disable iff (!NRST)
		(!auto_inc_r && !(wr_pulse && reg_sel_c)) |=> ptr_r == $past(ptr_r);
	endproperty
	a_ptr_hold: assert property (p_ptr_hold) else $error("pointer moved");

	property p_inc;
		@(posedge REF_CLK) disable iff (!NRST)
		(wr_pulse && reg_sel_d && auto_inc_r && fifo_in_ready && step == 3'h4)
		|=> ptr_r == 11'($past(ptr_r) + 11'h004);
	endproperty
	a_inc: assert property (p_inc) else $error("bad increment");

	property p_enq;
		@(posedge REF_CLK) disable iff (!NRST)
		(wr_pulse && reg_sel_c && DIN[0]) |=> (TX_ENQUEUE && ptr_r == $past(TX_NEXT_FREE));
	endproperty
	a_enq: assert property (p_enq) else $error("enqueue fault");

	property p_rel;
		@(posedge REF_CLK) disable iff (!NRST)
		(wr_pulse && reg_sel_q && DIN[0]) |=> (RX_RELEASE && rx_queue_command_r[0]);
	endproperty
	a_rel: assert property (p_rel) else $error("release not issued");

	property p_selfclr;
		@(posedge REF_CLK) disable iff (!NRST)
		(RX_RELEASED && !(wr_pulse && reg_sel_q && DIN[0])) |=> !rx_queue_command_r[0];
	endproperty
	a_selfclr: assert property (p_selfclr) else $error("release stuck");

	property p_block;
		@(posedge REF_CLK) disable iff (!NRST)
		(start_acc && wr_pulse && !reg_sel_q) |=> bthr_r == $past(bthr_r);
	endproperty
	a_block: assert property (p_block) else $error("register not blocked");

	property p_thr;
		@(posedge REF_CLK) disable iff (!NRST)
		(rx_queue_command_r[6] && byte_hit && !(wr_pulse && reg_sel_i && DIN[13])) |=> RX_INT;
	endproperty
	a_thr: assert property (p_thr) else $error("byte threshold missed");

	property p_sts;
		@(posedge REF_CLK) disable iff (!NRST)
		!(wr_pulse && reg_sel_i && DIN[13]) |=> $stable(sts_r);
	endproperty
	a_sts: assert property (p_sts) else $error("status changed");
endmodule // qctp_core

// >>> dv/qctp_far_model.sv
// Far-side model of the receive queue and the transmit queue sink.
`timescale 1ns/1ps
module qctp_far_model (
	input  wire logic                 clk,
	input  wire logic                 nrst,
	input  wire logic                 stall,
	input  wire logic [15:0]          byte_cnt,
	input  wire logic [7:0]           frame_cnt,
	input  wire logic                 frame_end,
	input  wire logic [31:0]          rx_word,
	output qctp_pkg::qctp_rxstat_type rx_stat,
	output logic [31:0]               rx_data,
	input  wire logic                 rx_read,
	input  wire logic                 rx_release,
	output logic                      rx_released,
	input  wire logic                 tx_valid,
	output logic                      tx_ready,
	output int                        acc_count,
	output int                        read_count
);
	logic [4:0] rel_wait;

	assign rx_stat = '{frame_end, 1'h1, byte_cnt, frame_cnt};
	assign rx_data = rx_word;

	// Ready is random when not stalled, and freeing memory takes a while.
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rel_wait <= 5'h00;
			rx_released <= 1'h0;
			tx_ready <= 1'h0;
			acc_count <= 0;
			read_count <= 0;
		end else begin
			tx_ready <= !stall && ($urandom % 4 != 0);
			rx_released <= (rel_wait == 5'h01);
			if (rx_release)
				rel_wait <= 5'h1E;
			else if (rel_wait != 5'h00)
				rel_wait <= rel_wait - 5'h01;
			if (tx_valid && tx_ready)
				acc_count <= acc_count + 1;
			if (rx_read)
				read_count <= read_count + 1;
		end
	end
endmodule // qctp_far_model

// >>> dv/tb_qctp_core.sv
// Self-checking testbench of the queue command and transmit pointer block.
`timescale 1ns/1ps
module tb_qctp_core;
	logic                      ref_clk = 1'h0;
	logic                      nrst = 1'h0;
	logic                      csn = 1'h1, rd_n = 1'h1, wr_n = 1'h1;
	logic [7:0]                addr = 8'h00;
	logic [3:0]                be_n = 4'hF, be;
	logic [31:0]               din = 32'h0, dout, rx_data, q, rx_word = 32'h0;
	logic                      dout_oe, rx_read, rx_dequeue, rx_release, rx_released, rx_int;
	logic [1:0]                rx_status;
	logic                      tx_valid, tx_ready, tx_enqueue, tx_full;
	logic [10:0]               tx_ptr, exp_ptr, next_free = 11'h000;
	logic                      stall = 1'h0, frame_end = 1'h0;
	logic [15:0]               byte_cnt = 16'h0, thr_b;
	logic [7:0]                frame_cnt = 8'h0, thr_f;
	logic [3:0]                bes [5] = '{4'h0, 4'h3, 4'hC, 4'hE, 4'h7};
	qctp_pkg::qctp_rxstat_type rx_stat;
	qctp_pkg::qctp_word_type   tx_word;
	int                        err_total = 0, check_count = 0, acc_count, read_count;
	int                        enq_seen = 0, rel_seen = 0, n;

	always #2.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		if (tx_enqueue === 1'h1) enq_seen++;
		if (rx_release === 1'h1) rel_seen++;
	end

	qctp_core i_qctp_core (.REF_CLK(ref_clk), .NRST(nrst), .CSN(csn), .RD_N(rd_n),
		.WR_N(wr_n), .ADDR(addr), .BE_N(be_n), .DIN(din), .DOUT(dout), .DOUT_OE(dout_oe),
		.RX_STAT(rx_stat), .RX_DATA(rx_data), .RX_READ(rx_read), .RX_DEQUEUE(rx_dequeue),
		.RX_RELEASE(rx_release), .RX_RELEASED(rx_released), .RX_INT(rx_int),
		.RX_STATUS(rx_status), .TX_VALID(tx_valid), .TX_READY(tx_ready), .TX_WORD(tx_word),
		.TX_PTR(tx_ptr), .TX_ENQUEUE(tx_enqueue), .TX_NEXT_FREE(next_free), .TX_FULL(tx_full));

	qctp_far_model i_qctp_far_model (.clk(ref_clk), .nrst(nrst), .stall(stall),
		.byte_cnt(byte_cnt), .frame_cnt(frame_cnt), .frame_end(frame_end), .rx_word(rx_word),
		.rx_stat(rx_stat), .rx_data(rx_data), .rx_read(rx_read), .rx_release(rx_release),
		.rx_released(rx_released), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.acc_count(acc_count), .read_count(read_count));

	////////////////////////////////////////////////////////////////////////////////
	// One host strobe cycle, held six cycles low and four high.
	task automatic bus(input logic wr, input logic [7:0] a, input logic [3:0] b,
		input logic [31:0] d);
		@(negedge ref_clk);
		addr = a;
		be_n = b;
		din = d;
		csn = 1'h0;
		if (wr) wr_n = 1'h0; else rd_n = 1'h0;
		repeat (6) @(negedge ref_clk);
		q = dout;
		csn = 1'h1;
		wr_n = 1'h1;
		rd_n = 1'h1;
		repeat (4) @(negedge ref_clk);
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic drain();
		for (int k = 0; k < 200 && tx_valid !== 1'h0; k++) @(negedge ref_clk);
	endtask

	function automatic logic [10:0] step(input logic [3:0] b);
		return (b == 4'h0) ? 11'h004 : (b == 4'h3 || b == 4'hC) ? 11'h002 : 11'h001;
	endfunction

	task automatic stop_test();
		if (err_total == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		void'($urandom(85553));
		repeat (10) @(negedge ref_clk);
		nrst = 1'h1;
		bus(0, qctp_pkg::ADDR_TX_FRAME_DATA_POINTER_OFS, 4'h0, 32'h0);
		chk(q[15:0], qctp_pkg::RESET_WORD);
		bus(1, qctp_pkg::ADDR_TX_FRAME_DATA_POINTER_OFS, 4'h0, 32'h000047FF);
		bus(0, qctp_pkg::ADDR_TX_FRAME_DATA_POINTER_OFS, 4'h0, 32'h0);
		chk(q[15:0], 16'h4000);
		exp_ptr = 11'h000;
		stall = 1'h1;
		for (int i = 0; i < 18; i++) begin
			be = bes[$urandom % 5];
			bus(1, qctp_pkg::ADDR_DATA_OFS, be, $urandom);
			if (i < 16) exp_ptr += step(be);
			bus(0, qctp_pkg::ADDR_TX_FRAME_DATA_POINTER_OFS, 4'h0, 32'h0);
			chk(q[10:0], exp_ptr);
		end
		chk(tx_full, 1'h1);
		stall = 1'h0;
		drain();
		chk(acc_count, 16);
		bus(1, qctp_pkg::ADDR_TX_FRAME_DATA_POINTER_OFS, 4'h0, 32'h0);
		bus(1, qctp_pkg::ADDR_DATA_OFS, 4'h0, $urandom);
		bus(0, qctp_pkg::ADDR_TX_FRAME_DATA_POINTER_OFS, 4'h0, 32'h0);
		chk(q[15:0], {5'h00, exp_ptr});
		next_free = 11'($urandom);
		bus(1, qctp_pkg::ADDR_TXQCR_OFS, 4'h0, 32'h1);
		chk(enq_seen, 1);
		bus(0, qctp_pkg::ADDR_TX_FRAME_DATA_POINTER_OFS, 4'h0, 32'h0);
		chk(q[10:0], next_free);
		rx_word = $urandom;
		drain();
		n = acc_count;
		bus(1, qctp_pkg::ADDR_RX_QUEUE_COMMAND_OFS, 4'h0, 32'h8);
		bus(0, qctp_pkg::ADDR_TX_FRAME_DATA_POINTER_OFS, 4'h0, 32'h0);
		chk(q, rx_word);
		chk(read_count, 1);
		stall = 1'h1;
		bus(1, qctp_pkg::ADDR_TX_FRAME_DATA_POINTER_OFS, 4'hF, 32'h00004000);
		chk(dout_oe, 1'h0);
		chk(tx_valid, 1'h1);
		chk(tx_word[35:32], 4'hF);
		chk(tx_word[31:0], 32'h00004000);
		stall = 1'h0;
		drain();
		chk(acc_count, n + 1);
		bus(1, qctp_pkg::ADDR_RX_QUEUE_COMMAND_OFS, 4'h0, 32'h0);
		bus(0, qctp_pkg::ADDR_TX_FRAME_DATA_POINTER_OFS, 4'h0, 32'h0);
		chk(q[15:0], {5'h00, next_free});
		bus(1, qctp_pkg::ADDR_RX_QUEUE_COMMAND_OFS, 4'h0, 32'h1);
		chk(rel_seen, 1);
		bus(0, qctp_pkg::ADDR_RX_QUEUE_COMMAND_OFS, 4'h0, 32'h0);
		chk(q[0], 1'h1);
		for (int i = 0; i < 10 && q[0] !== 1'h0; i++)
			bus(0, qctp_pkg::ADDR_RX_QUEUE_COMMAND_OFS, 4'h0, 32'h0);
		chk(q[0], 1'h0);
		thr_b = 16'($urandom % 16'hFF00);
		thr_f = 8'($urandom % 8'hF0);
		byte_cnt = thr_b;
		frame_cnt = thr_f + 8'h01;
		bus(1, qctp_pkg::ADDR_BTHR_OFS, 4'h0, {16'h0, thr_b});
		bus(1, qctp_pkg::ADDR_FTHR_OFS, 4'h0, {24'h0, thr_f});
		bus(1, qctp_pkg::ADDR_RX_QUEUE_COMMAND_OFS, 4'h0, 32'h70);
		bus(1, qctp_pkg::ADDR_ISR_OFS, 4'h0, 32'h2000);
		chk(rx_status, 2'h1);
		chk(rx_int, 1'h1);
		byte_cnt = thr_b + 16'h0001;
		frame_cnt = thr_f;
		repeat (4) @(negedge ref_clk);
		chk(rx_status, 2'h1);
		bus(1, qctp_pkg::ADDR_ISR_OFS, 4'h0, 32'h2000);
		chk(rx_status, 2'h2);
		chk(rx_int, 1'h1);
		byte_cnt = thr_b;
		bus(1, qctp_pkg::ADDR_ISR_OFS, 4'h0, 32'h2000);
		chk(rx_status, 2'h0);
		chk(rx_int, 1'h0);
		frame_end = 1'h1;
		@(negedge ref_clk);
		chk(rx_dequeue, 1'h1);
		bus(1, qctp_pkg::ADDR_RX_QUEUE_COMMAND_OFS, 4'h0, 32'h0);
		chk(rx_dequeue, 1'h0);
		stop_test();
	end

	initial begin
		#50us;
		err_total++;
		stop_test();
	end
endmodule // tb_qctp_core
